//--- src/umie_mode_irq.sv
/*
 * Mode register and interrupt enable logic of a serial transceiver, with an
 * AXI4-Lite slave, baud clock selection, channel routing, receive filter and
 * smart-card NACK retry control.
 * Assumes the transmitter and receiver sit outside and run on aclk; pin inputs
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module umie_mode_irq #(
   parameter int AW = umie_pkg::ADDR_W
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [AW-1:0]        s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [AW-1:0]        s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 rxd_pin,
   output logic                      txd_pin,
   input  wire logic                 ext_serial_clock,
   output logic                      sck_out,
   output logic                      sck_oe,
   input  wire logic                 tx_bit,
   output logic                      rx_bit,
   input  wire logic                 rx_char_done,
   input  wire logic                 rx_check_err,
   input  wire logic                 thr_write,
   input  wire logic                 thr_cmd_sync,
   input  wire logic [31:0]          line_events,
   output logic                      nack_send,
   output logic                      retry_limit_reached,
   output logic                      frame_cmd_sync,
   output logic                      baud_tick,
   output umie_pkg::umie_proto_t     line_protocol,
   output umie_pkg::umie_parity_t    check_bit_kind,
   output logic [3:0]                char_bits,
   output logic [2:0]                stop_halves,
   output logic [4:0]                oversample_ratio,
   output logic                      sync_mode,
   output logic                      msb_first,
   output logic                      biphase_on,
   output logic                      single_delim,
   output logic                      biphase_start_seen,
   output logic                      irq
);
   import umie_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [31:0] mode_reg;
   logic [31:0] mask;
   logic [31:0] status;
   logic [AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;
   logic [31:0] wr_bits;
   logic        wr_mode, wr_ier, wr_idr, wr_stat, wr_known;
   logic [2:0]  div_cnt;
   logic [2:0]  ext_sync;
   logic [1:0]  rx_sync;
   logic        rx_prev;
   logic        rx_voted;
   logic        rx_line;
   logic [2:0]  retry_event_cnt;
   logic        retry_pulse;
   logic [31:0] next_status;
   logic        next_tick;

   wire [3:0] f_proto  = mode_reg[MR_PROTO +: 4];
   wire [1:0] f_clksrc = mode_reg[MR_CLKSRC +: 2];
   wire [1:0] f_char_length_code   = mode_reg[MR_CHAR_LENGTH_CODE +: 2];
   wire [2:0] f_par    = mode_reg[MR_PAR +: 3];
   wire [1:0] f_stop   = mode_reg[MR_STOP +: 2];
   wire [1:0] f_channel_test_mode = mode_reg[MR_CHANNEL_TEST_MODE +: 2];
   wire [2:0] f_maxit  = mode_reg[MR_MAXIT +: 3];
   wire       iso_mode = (f_proto == PROTO_ISO_T0) || (f_proto == PROTO_ISO_T1);

   // Write path: address and data are held separately and committed together.
   assign wr_fire  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_bits  = w_data & umie_strb(w_strb);
   assign wr_mode  = wr_fire && (aw_addr[7:0] == OFF_MODE);
   assign wr_ier   = wr_fire && (aw_addr[7:0] == OFF_IER);
   assign wr_idr   = wr_fire && (aw_addr[7:0] == OFF_IDR);
   assign wr_stat  = wr_fire && (aw_addr[7:0] == OFF_STAT);
   assign wr_known = wr_mode || wr_ier || wr_idr || wr_stat || (aw_addr[7:0] == OFF_IMR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr       <= '0;
         w_data        <= ZERO_W;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read path answers one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ZERO_W;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         unique case (s_axi_araddr[7:0])
            OFF_MODE: s_axi_rdata <= mode_reg;
            OFF_IER:  s_axi_rdata <= ZERO_W;
            OFF_IDR:  s_axi_rdata <= ZERO_W;
            OFF_IMR:  s_axi_rdata <= mask;
            OFF_STAT: s_axi_rdata <= status;
            default: begin
               s_axi_rdata <= ZERO_W;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= MODE_RST;
      end else if (wr_mode) begin
         mode_reg <= (mode_reg & ~(umie_strb(w_strb) & MODE_WMASK))
                   | (wr_bits & MODE_WMASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask <= ZERO_W;
      end else if (wr_ier) begin
         mask <= mask | umie_fold(wr_bits);
      end else if (wr_idr) begin
         mask <= mask & ~umie_fold(wr_bits);
      end
   end

   // A new event wins over a clear written in the same cycle.
   always_comb begin
      next_status = status & ~(wr_stat ? umie_fold(wr_bits) : ZERO_W);
      next_status = next_status | umie_fold(line_events);
      next_status[BIT_RETRY] = next_status[BIT_RETRY] | retry_pulse;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= ZERO_W;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         irq    <= |(next_status & mask);
      end
   end

   // Pin synchronisers; logic takes the second stage, and edge detection also takes the third.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 3'h0;
         rx_sync  <= 2'h3;
         rx_prev  <= 1'b1;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_serial_clock};
         rx_sync  <= {rx_sync[0], rxd_pin};
         rx_prev  <= rx_sync[1];
      end
   end

   always_comb begin
      unique case (f_clksrc)
         CLK_MAIN: next_tick = 1'b1;
         CLK_DIV8: next_tick = (div_cnt == 3'(DIV_MAIN - 1));
         CLK_EXT:  next_tick = ext_sync[1] && !ext_sync[2];
         default:  next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt   <= 3'h0;
         baud_tick <= 1'b0;
         sck_out   <= 1'b0;
         sck_oe    <= 1'b0;
      end else begin
         div_cnt   <= div_cnt + 3'h1;
         baud_tick <= next_tick;
         if (next_tick) begin
            sck_out <= !sck_out;
         end
         sck_oe <= mode_reg[MR_SERIAL_CLOCK_OUT_ENABLE] && (f_clksrc != CLK_EXT);
      end
   end

   umie_vote3 u_vote (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sample_en (baud_tick),
      .din       (rx_sync[1]),
      .dout      (rx_voted)
   );

   assign rx_line = mode_reg[MR_FILTER] ? rx_voted : rx_sync[1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_pin <= 1'b1;
         rx_bit  <= 1'b1;
      end else begin
         unique case (f_channel_test_mode)
            CHM_NORMAL: begin
               txd_pin <= tx_bit;
               rx_bit  <= rx_line;
            end
            CHM_ECHO: begin
               txd_pin <= rx_line;
               rx_bit  <= rx_line;
            end
            CHM_LOCAL: begin
               txd_pin <= 1'b1;
               rx_bit  <= tx_bit;
            end
            CHM_REMOTE: begin
               txd_pin <= rx_sync[1];
               rx_bit  <= 1'b1;
            end
         endcase
      end
   end

   // Smart-card NACK handling; a good character restarts the error count.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retry_event_cnt            <= 3'h0;
         nack_send           <= 1'b0;
         retry_pulse         <= 1'b0;
         retry_limit_reached <= 1'b0;
      end else begin
         nack_send   <= 1'b0;
         retry_pulse <= 1'b0;
         if (wr_stat && wr_bits[BIT_RETRY]) begin
            retry_limit_reached <= 1'b0;
         end
         if (rx_char_done && iso_mode) begin
            if (!rx_check_err) begin
               retry_event_cnt <= 3'h0;
            end else if (!mode_reg[MR_NACK_LIMIT_ENABLE]) begin
               nack_send <= !mode_reg[MR_NACK_INHIBIT];
            end else if (retry_event_cnt < f_maxit) begin
               retry_event_cnt  <= retry_event_cnt + 3'h1;
               nack_send <= !mode_reg[MR_NACK_INHIBIT];
            end else begin
               retry_pulse         <= 1'b1;
               retry_limit_reached <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_cmd_sync <= 1'b0;
      end else if (!mode_reg[MR_VARSYNC]) begin
         frame_cmd_sync <= mode_reg[MR_SYNC];
      end else if (thr_write) begin
         frame_cmd_sync <= thr_cmd_sync;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         biphase_start_seen <= 1'b0;
      end else begin
         biphase_start_seen <= mode_reg[MR_MAN] && (rx_line != rx_prev)
                               && (rx_line == !mode_reg[MR_BIPHASE_START_POLARITY]);
      end
   end

   // Decoded configuration for the datapaths.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_protocol    <= PROTO_T_NORMAL;
         check_bit_kind   <= PAR_EVEN;
         char_bits        <= CHAR_BASE;
         stop_halves      <= STOP_H_ONE;
         oversample_ratio <= OVS_16;
         sync_mode        <= 1'b0;
         msb_first        <= 1'b0;
         biphase_on       <= 1'b0;
         single_delim     <= 1'b0;
      end else begin
         unique case (f_proto)
            PROTO_NORMAL: line_protocol <= PROTO_T_NORMAL;
            PROTO_RS485:  line_protocol <= PROTO_T_RS485;
            PROTO_HSHAKE: line_protocol <= PROTO_T_HSHAKE;
            PROTO_MODEM:  line_protocol <= PROTO_T_MODEM;
            PROTO_ISO_T0: line_protocol <= PROTO_T_ISO_T0;
            PROTO_ISO_T1: line_protocol <= PROTO_T_ISO_T1;
            PROTO_IRDA:   line_protocol <= PROTO_T_IRDA;
            default:      line_protocol <= PROTO_T_RESERVED;
         endcase
         unique casez (f_par)
            3'b000:  check_bit_kind <= PAR_EVEN;
            3'b001:  check_bit_kind <= PAR_ODD;
            3'b010:  check_bit_kind <= PAR_SPACE;
            3'b011:  check_bit_kind <= PAR_MARK;
            3'b10?:  check_bit_kind <= PAR_NONE;
            default: check_bit_kind <= PAR_MULTIDROP;
         endcase
         char_bits <= mode_reg[MR_NINE_BIT_CHARS] ? CHAR_NINE : CHAR_BASE + {2'h0, f_char_length_code};
         // Reserved stop codes fall back to one stop bit.
         if (f_stop == STOP_C_TWO) begin
            stop_halves <= STOP_H_TWO;
         end else if (f_stop == STOP_C_HALF && !mode_reg[MR_SYNC]) begin
            stop_halves <= STOP_H_HALF;
         end else begin
            stop_halves <= STOP_H_ONE;
         end
         oversample_ratio <= mode_reg[MR_OVER] ? OVS_8 : OVS_16;
         sync_mode        <= mode_reg[MR_SYNC];
         msb_first        <= mode_reg[MR_HIGH_BIT_FIRST];
         biphase_on       <= mode_reg[MR_MAN];
         single_delim     <= mode_reg[MR_SINGLE_BIT_DELIMITER];
      end
   end

   AST_IRQ_CAUSE: assert property (
      irq |-> |($past(status) & $past(mask)) || |(status & mask))
      else $error("interrupt without an enabled status bit");
   AST_IER_SETS: assert property (
      wr_ier |=> ((mask & $past(umie_fold(wr_bits))) == $past(umie_fold(wr_bits))))
      else $error("enable write did not set mask bits");
   AST_IER_KEEPS: assert property (
      wr_ier |=> ((mask & $past(mask)) == $past(mask)))
      else $error("enable write cleared a mask bit");
   AST_IER_UNREAD: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == OFF_IER |=> s_axi_rdata == ZERO_W)
      else $error("enable register returned data");
   // The first tick after a switch to the divider is left over from the old source.
   AST_DIV8_GAP: assert property (
      baud_tick && f_clksrc == CLK_DIV8 && $past(f_clksrc) == CLK_DIV8
      |=> (!baud_tick || f_clksrc != CLK_DIV8) [*7])
      else $error("divided baud tick came too soon");
   AST_SCK_DRIVE: assert property (
      sck_oe |-> $past(mode_reg[MR_SERIAL_CLOCK_OUT_ENABLE]) && $past(f_clksrc) != CLK_EXT)
      else $error("clock pin driven while external clock selected");
   AST_NINE_BIT: assert property (
      mode_reg[MR_NINE_BIT_CHARS] ##1 mode_reg[MR_NINE_BIT_CHARS] |-> char_bits == CHAR_NINE)
      else $error("nine-bit length not applied");
   AST_LOCAL_IDLE: assert property (
      f_channel_test_mode == CHM_LOCAL |=> txd_pin)
      else $error("transmit pin not idle in local loopback");
   AST_REMOTE_COPY: assert property (
      f_channel_test_mode == CHM_REMOTE |=> txd_pin == $past(rx_sync[1]))
      else $error("remote loopback did not copy receive pin");
   AST_NACK_INHIBIT: assert property (
      nack_send |-> !$past(mode_reg[MR_NACK_INHIBIT]) && $past(rx_check_err))
      else $error("NACK sent while inhibited or without error");
   AST_NACK_LIMIT: assert property (
      nack_send && $past(mode_reg[MR_NACK_LIMIT_ENABLE]) |-> $past(retry_event_cnt) < $past(f_maxit))
      else $error("NACK sent beyond retry limit");
   AST_RETRY_FLAG: assert property (
      retry_pulse |=> status[BIT_RETRY] && retry_limit_reached)
      else $error("retry limit not flagged");

   COV_RETRY: cover property (retry_pulse);
   COV_NACK: cover property (nack_send ##[1:100] nack_send);
   COV_IRQ: cover property (!irq ##1 irq);
   COV_EXT_TICK: cover property (baud_tick && f_clksrc == CLK_EXT);

endmodule

//--- src/umie_pkg.sv
/*
 * Constants, field layout and types for the serial transceiver mode and
 * interrupt enable block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package umie_pkg;

   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;

   localparam logic [7:0]  OFF_MODE    = 8'h04;
   localparam logic [7:0]  OFF_IER     = 8'h08;
   localparam logic [7:0]  OFF_IDR     = 8'h0C;
   localparam logic [7:0]  OFF_IMR     = 8'h10;
   localparam logic [7:0]  OFF_STAT    = 8'h14;

   localparam logic [31:0] MODE_RST    = 32'h0000_0000;
   localparam logic [31:0] MODE_WMASK  = 32'hF77F_FFFF;
   localparam logic [31:0] IRQ_VALID   = 32'h011F_3FFF;
   localparam logic [31:0] ZERO_W      = 32'h0000_0000;

   localparam int MR_PROTO   = 0;
   localparam int MR_CLKSRC  = 4;
   localparam int MR_CHAR_LENGTH_CODE    = 6;
   localparam int MR_SYNC    = 8;
   localparam int MR_PAR     = 9;
   localparam int MR_STOP    = 12;
   localparam int MR_CHANNEL_TEST_MODE  = 14;
   localparam int MR_HIGH_BIT_FIRST    = 16;
   localparam int MR_NINE_BIT_CHARS   = 17;
   localparam int MR_SERIAL_CLOCK_OUT_ENABLE    = 18;
   localparam int MR_OVER    = 19;
   localparam int MR_NACK_INHIBIT   = 20;
   localparam int MR_NACK_LIMIT_ENABLE  = 21;
   localparam int MR_VARSYNC = 22;
   localparam int MR_MAXIT   = 24;
   localparam int MR_FILTER  = 28;
   localparam int MR_MAN     = 29;
   localparam int MR_BIPHASE_START_POLARITY = 30;
   localparam int MR_SINGLE_BIT_DELIMITER  = 31;

   localparam int BIT_RETRY   = 10;
   localparam int BIT_BIPH_LO = 20;
   localparam int BIT_BIPH_HI = 24;

   localparam logic [3:0] PROTO_NORMAL = 4'h0;
   localparam logic [3:0] PROTO_RS485  = 4'h1;
   localparam logic [3:0] PROTO_HSHAKE = 4'h2;
   localparam logic [3:0] PROTO_MODEM  = 4'h3;
   localparam logic [3:0] PROTO_ISO_T0 = 4'h4;
   localparam logic [3:0] PROTO_ISO_T1 = 4'h6;
   localparam logic [3:0] PROTO_IRDA   = 4'h8;

   localparam logic [1:0] CLK_MAIN = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_EXT  = 2'h3;
   localparam int         DIV_MAIN = 8;

   localparam logic [1:0] CHM_NORMAL = 2'h0;
   localparam logic [1:0] CHM_ECHO   = 2'h1;
   localparam logic [1:0] CHM_LOCAL  = 2'h2;
   localparam logic [1:0] CHM_REMOTE = 2'h3;

   localparam logic [1:0] STOP_C_ONE  = 2'h0;
   localparam logic [1:0] STOP_C_HALF = 2'h1;
   localparam logic [1:0] STOP_C_TWO  = 2'h2;
   localparam logic [2:0] STOP_H_ONE  = 3'h2;
   localparam logic [2:0] STOP_H_HALF = 3'h3;
   localparam logic [2:0] STOP_H_TWO  = 3'h4;

   localparam logic [3:0] CHAR_BASE = 4'h5;
   localparam logic [3:0] CHAR_NINE = 4'h9;
   localparam logic [4:0] OVS_16    = 5'h10;
   localparam logic [4:0] OVS_8     = 5'h08;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PROTO_T_NORMAL, PROTO_T_RS485, PROTO_T_HSHAKE, PROTO_T_MODEM,
      PROTO_T_ISO_T0, PROTO_T_ISO_T1, PROTO_T_IRDA, PROTO_T_RESERVED
   } umie_proto_t;

   typedef enum logic [2:0] {
      PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK, PAR_NONE, PAR_MULTIDROP
   } umie_parity_t;

   // The biphase error enable sits at two positions; both read and act as one bit.
   function automatic logic [31:0] umie_fold(input logic [31:0] x);
      logic [31:0] r;
      r = x & IRQ_VALID;
      r[BIT_BIPH_LO] = x[BIT_BIPH_LO] | x[BIT_BIPH_HI];
      r[BIT_BIPH_HI] = x[BIT_BIPH_LO] | x[BIT_BIPH_HI];
      return r;
   endfunction

   function automatic logic [31:0] umie_strb(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

endpackage

//--- src/umie_vote3.sv
/*
 * Three-sample two-of-three majority filter for the receive line.
 * Assumes din is already synchronised to aclk and sample_en is a one-cycle pulse.
 */
`timescale 1ns/1ps
module umie_vote3 (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sample_en,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] taps;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         taps <= 3'h7;
         dout <= 1'b1;
      end else if (sample_en) begin
         taps <= {taps[1:0], din};
         dout <= (taps[1] & taps[0]) | (taps[1] & din) | (taps[0] & din);
      end
   end

   AST_VOTE_MAJ: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_en && (taps[1:0] == 2'h0) |=> !dout)
      else $error("vote filter passed a lone one");

endmodule

//--- testbench/umie_line_peer.sv
/*
 * Remote serial device that drives the receive line of the block.
 * Assumes the bench tells it when to drive and what level to put on the line.
 */
`timescale 1ns/1ps
module umie_line_peer (
   input  wire logic aclk,
   input  wire logic drive,
   input  wire logic level,
   output logic      rxd_pin
);
   initial rxd_pin = 1'h1;
   // A released line rests at mark, as an idle serial line does.
   always @(posedge aclk) begin
      rxd_pin <= drive ? level : 1'h1;
   end
endmodule

//--- testbench/test_usart_mode_and_irq_enable.sv
/*
 * Self-checking bench for the mode and interrupt enable block.
 * Assumes the line peer model and the design sources are compiled first.
 */
`timescale 1ns/1ps
module test_usart_mode_and_irq_enable;
   import umie_pkg::*;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, tx_bit = '1, ext_serial_clock = '0;
   logic rx_char_done = '0, rx_check_err = '0, thr_write = '0, thr_cmd_sync = '0;
   logic pdrive = '0, plevel = '1, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, rxd_pin, txd_pin, sck_oe, rx_bit, nack_send;
   logic baud_tick, irq, sync_mode, msb_first, biphase_on, single_delim;
   logic sck_out, retry_limit_reached, frame_cmd_sync, biphase_start_seen;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, line_events = '0, rd_v, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF, char_bits;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [2:0]  stop_halves;
   logic [4:0]  oversample_ratio;
   umie_proto_t  line_protocol;
   umie_parity_t check_bit_kind;
   int fails = 0, compares = 0, cyc = 0, n;
   umie_mode_irq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_pin, .txd_pin, .ext_serial_clock,
      .sck_out, .sck_oe, .tx_bit, .rx_bit, .rx_char_done, .rx_check_err, .thr_write,
      .thr_cmd_sync, .line_events, .nack_send, .retry_limit_reached, .frame_cmd_sync,
      .baud_tick, .line_protocol, .check_bit_kind, .char_bits, .stop_halves,
      .oversample_ratio, .sync_mode, .msb_first, .biphase_on, .single_delim,
      .biphase_start_seen, .irq);
   umie_line_peer peer (.aclk, .drive(pdrive), .level(plevel), .rxd_pin);
   always #12.5 aclk = ~aclk;
   task automatic results();
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // About seventeen times the expected run length, so a stuck handshake ends the run.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         fails = fails + 1;
         results();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd_v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic nk(input logic [31:0] e);
      @(posedge aclk);
      {rx_char_done, rx_check_err} <= 2'h3;
      n = 0;
      repeat (4) begin
         @(posedge aclk);
         rx_char_done <= 1'h0;
         #1;
         if (nack_send === 1'h1) n++;
      end
      chk(32'(n), e);
   endtask
   task automatic t_proto();
      logic [3:0] code [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
      rd(OFF_MODE);
      chk(rd_v, MODE_RST);
      for (int i = 0; i < 7; i++) begin
         wr(OFF_MODE, {28'h0, code[i]});
         tick(2);
         chk(32'(line_protocol), 32'(i));
      end
   endtask
   task automatic t_fields();
      wr(OFF_MODE, 32'hA009_22C0);
      rd(OFF_MODE);
      chk(rd_v, 32'hA009_22C0);
      chk({char_bits, 1'h0, check_bit_kind, 1'h0, stop_halves}, 32'h814);
      chk({oversample_ratio, msb_first, sync_mode, biphase_on, single_delim}, 32'h8B);
      wr(OFF_MODE, 32'hFFFF_EFF8);
      rd(OFF_MODE);
      chk(rd_v, 32'hF77F_EFF8);
      chk({char_bits, 1'h0, check_bit_kind}, 32'h95);
      chk({msb_first, sync_mode, biphase_on, single_delim}, 32'hF);
   endtask
   task automatic t_irq();
      wr(OFF_IER, 32'h0100_0001);
      wr(OFF_IER, ZERO_W);
      rd(OFF_IMR);
      chk(rd_v, 32'h0110_0001);
      rd(OFF_IER);
      chk(rd_v, ZERO_W);
      rd(8'h40);
      chk(32'(rs), 32'(RESP_SLVERR));
      wr(8'h40, ZERO_W);
      chk(32'(rs), 32'(RESP_SLVERR));
      @(posedge aclk);
      line_events <= 32'h3;
      @(posedge aclk);
      line_events <= '0;
      tick(2);
      chk(32'(irq), 32'h1);
      wr(OFF_STAT, 32'h1);
      chk(32'(rs), 32'(RESP_OKAY));
      tick(2);
      chk(32'(irq), 32'h0);
   endtask
   task automatic t_route();
      wr(OFF_MODE, 32'h8000);
      tx_bit <= 1'h0;
      tick(3);
      chk({txd_pin, rx_bit}, 32'h2);
      wr(OFF_MODE, 32'hC000);
      {tx_bit, pdrive, plevel} <= 3'h6;
      tick(6);
      chk(32'(txd_pin), 32'h0);
      wr(OFF_MODE, 32'h4000);
      tick(3);
      chk({txd_pin, rx_bit}, 32'h0);
      wr(OFF_MODE, ZERO_W);
      tick(3);
      chk({txd_pin, rx_bit}, 32'h2);
      pdrive <= 1'h0;
   endtask
   task automatic t_baud();
      logic s;
      int m;
      wr(OFF_MODE, 32'h0004_0010);
      tick(2);
      n = 0;
      m = 0;
      s = sck_out;
      repeat (16) begin
         tick(1);
         if (baud_tick === 1'h1) n++;
         if (sck_out !== s) m++;
         s = sck_out;
      end
      chk(32'(n), 32'h2);
      chk(32'(m), 32'h2);
      chk(32'(sck_oe), 32'h1);
      wr(OFF_MODE, 32'h0004_0030);
      tick(2);
      chk(32'(sck_oe), 32'h0);
      // Four rising edges on the external clock pin must give four ticks.
      n = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         ext_serial_clock <= (i < 32) && i[2];
         #1;
         if (baud_tick === 1'h1) n++;
      end
      chk(32'(n), 32'h4);
   endtask
   task automatic t_sync();
      int m;
      wr(OFF_MODE, 32'h0000_0100);
      tick(2);
      chk(32'(frame_cmd_sync), 32'h1);
      wr(OFF_MODE, 32'h0040_0000);
      tick(2);
      chk(32'(frame_cmd_sync), 32'h1);
      @(posedge aclk);
      thr_write <= 1'h1;
      @(posedge aclk);
      thr_write <= 1'h0;
      tick(2);
      chk(32'(frame_cmd_sync), 32'h0);
      // A falling then a rising line edge; only the selected one is a start.
      for (int p = 0; p < 2; p++) begin
         wr(OFF_MODE, {1'h0, p[0], 30'h2000_0000});
         m = 0;
         {pdrive, plevel} <= 2'h2;
         repeat (6) begin
            tick(1);
            if (biphase_start_seen === 1'h1) m += 16;
         end
         @(posedge aclk);
         pdrive <= 1'h0;
         repeat (6) begin
            tick(1);
            if (biphase_start_seen === 1'h1) m++;
         end
         chk(32'(m), p ? 32'h10 : 32'h01);
      end
   endtask
   task automatic t_nack();
      wr(OFF_MODE, 32'h4);
      nk(32'h1);
      wr(OFF_MODE, 32'h0010_0004);
      nk(32'h0);
      wr(OFF_MODE, 32'h0120_0004);
      nk(32'h1);
      nk(32'h0);
      chk(32'(retry_limit_reached), 32'h1);
      rd(OFF_STAT);
      chk(rd_v & 32'h400, 32'h400);
      wr(OFF_STAT, 32'h400);
      tick(2);
      chk(32'(retry_limit_reached), 32'h0);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_proto();
      t_fields();
      t_irq();
      t_route();
      t_baud();
      t_sync();
      t_nack();
      results();
   end
endmodule
